// >>> hw/gpt_timer.sv
// Behaviour
// - Two 16-bit counters A and B, joinable as 32-bit timer or RTC.
// - Own trigger is ORed with other units' triggers toward the ADC.
// - Reset: control cleared, counters and loads 0xFFFF, prescales 0x00.
// - Config 0 selects 32-bit one-shot/periodic, 1 selects 32-bit RTC.
// - Config 0x4 selects split 16-bit mode.
// - In 32-bit modes the unit acts only as one 32-bit timer.
// - 32-bit modes use only the even capture/compare pin.
// - 32-bit write to A load updates B load upper, A load lower.
// - Reading A count in 32-bit modes returns B count upper, A lower.
// - A mode field alone selects one-shot or periodic; B mode ignored.
// - Enable starts down-count; cycle after zero reloads joined load value.
// - One-shot stops and clears enable at zero; periodic keeps counting.
// - Zero sets A time-out raw flag until cleared; mask gives masked flag.
// - Trigger enabled: one-cycle pulse in the cycle counter reaches zero.
// - Load write while running: counter takes new value next cycle.
// - Stall bit plus stall signal holds the count until signal drops.
// - RTC mode up-counts; first selection loads counter with 0x00000001.
// - 32.768 kHz on even pin divided to 1 Hz advances the counter.
// - RTC counter rolls to zero on match, runs until reset or disable.
// - RTC match sets raw flag; with its mask bit set, also masked flag and interrupt; clear bit clears.
// - RTC enable set: counting ignores both stall bits.
`default_nettype none
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,          // System clock
  input  wire logic              resetn,        // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic              ccp_even_in,   // Even capture pin, RTC clock
  input  wire logic              stall_in,      // Stall request from debug
  input  wire logic              peer_trigger,  // Triggers of other units
  output logic                   adc_trigger,   // Combined ADC trigger
  output logic                   irq_out        // Controller interrupt
);
  import gpt_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
    $error("gpt_timer: ADDR_W must be 8..32");
  end

  typedef struct packed {
    logic [2:0]           cfg;
    logic [3:0]           a_mode_field;
    logic [3:0]           tbmr;
    logic [15:0]          ctl;
    logic [3:0]           imr;
    logic [3:0]           ris;
    logic [15:0]          tailr;
    logic [15:0]          tbilr;
    logic [31:0]          match;
    logic [7:0]           tapr;
    logic [7:0]           tbpr;
    logic [15:0]          ta_cnt;
    logic [15:0]          tb_cnt;
    logic                 rtc_seen;
    logic                 pin_s1;
    logic                 pin_s2;
    logic                 pin_s3;
    logic                 stall_s1;
    logic                 stall_s2;
    logic [RTC_DIV_W-1:0] presc;
    logic                 own_trig;
    logic                 adc_trig;
    logic                 irq;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } gpt_state_s;

  gpt_state_s s_reg;
  gpt_state_s s_next;

  logic        wr_fire;
  logic        rd_fire;
  logic        tick;
  logic        stalled;
  logic [31:0] cnt;
  logic [31:0] load32;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFS_CFG, OFS_A_MODE_FIELD, OFS_TBMR, OFS_CTL, OFS_IMR, OFS_RIS, OFS_MIS,
      OFS_ICR, OFS_TAILR, OFS_TBILR, OFS_TAMTCH, OFS_TAPR, OFS_TBPR,
      OFS_TAR, OFS_TBR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic is32(input logic [2:0] c);
    is32 = (c == CFG_32_TIMER) || (c == CFG_32_RTC);
  endfunction

  always_comb begin
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [31:0] cnt_n;
    logic [31:0] m;
    logic        pin_rise;
    logic        oneshot;
    wa = s_axi_awaddr[7:0];
    ra = s_axi_araddr[7:0];
    m = 32'h00000000;
    s_next = s_reg;
    cnt = {s_reg.tb_cnt, s_reg.ta_cnt};
    cnt_n = cnt;
    load32 = {s_reg.tbilr, s_reg.tailr};
    wr_fire = s_reg.awready && s_axi_awvalid && s_axi_wvalid;
    rd_fire = s_reg.arready && s_axi_arvalid;
    oneshot = (s_reg.a_mode_field[1:0] == MODE_ONESHOT);
    stalled = s_reg.ctl[CTL_A_STALL] && s_reg.stall_s2;
    tick = 1'b0;
    pin_rise = s_reg.pin_s2 && !s_reg.pin_s3;

    // Synchronisers
    s_next.pin_s1 = ccp_even_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_s3 = s_reg.pin_s2;
    s_next.stall_s1 = stall_in;
    s_next.stall_s2 = s_reg.stall_s1;

    s_next.own_trig = 1'b0;
    s_next.awready = 1'b0;
    s_next.wready = 1'b0;
    s_next.arready = 1'b0;

    // Software clear first so a same-cycle hardware set wins
    if (wr_fire && wa == OFS_ICR) begin
      if (s_axi_wstrb[0]) begin
        s_next.ris = s_reg.ris & ~s_axi_wdata[3:0];
      end
    end

    // Prescaler runs only in RTC mode while enabled
    if (s_reg.cfg == CFG_32_RTC && s_reg.ctl[CTL_A_EN]) begin
      if (pin_rise) begin
        if (s_reg.presc == RTC_DIV_W'(RTC_DIV - 1)) begin
          s_next.presc = '0;
          tick = 1'b1;
        end else begin
          s_next.presc = s_reg.presc + RTC_DIV_W'(1);
        end
      end
    end else begin
      s_next.presc = '0;
    end

    case (s_reg.cfg)
      CFG_32_TIMER: begin
        if (s_reg.ctl[CTL_A_EN] && !stalled) begin
          if (cnt == 32'h00000000) begin
            cnt_n = load32;
            if (oneshot) begin
              s_next.ctl[CTL_A_EN] = 1'b0;
            end
          end else begin
            cnt_n = cnt - 32'h00000001;
            if (cnt_n == 32'h00000000) begin
              s_next.ris[IRQ_A_TO] = 1'b1;
              s_next.own_trig = s_reg.ctl[CTL_A_OTE];
            end
          end
        end
      end
      CFG_32_RTC: begin
        if (s_reg.ctl[CTL_A_EN] && tick) begin
          if (cnt == s_reg.match) begin
            cnt_n = 32'h00000000;
            s_next.ris[IRQ_RTC] = 1'b1;
          end else begin
            cnt_n = cnt + 32'h00000001;
          end
        end
      end
      default: begin
        cnt_n = cnt;
      end
    endcase

    // Write channel
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !s_reg.awready && !s_reg.bvalid) begin
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    if (wr_fire) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        OFS_CFG: begin
          m = wmerge({29'h0, s_reg.cfg}, s_axi_wdata, s_axi_wstrb);
          s_next.cfg = m[2:0];
          if (m[2:0] == CFG_32_RTC && !s_reg.rtc_seen) begin
            s_next.rtc_seen = 1'b1;
            cnt_n = RTC_START;
          end
        end
        OFS_A_MODE_FIELD: begin
          m = wmerge({28'h0, s_reg.a_mode_field}, s_axi_wdata, s_axi_wstrb);
          s_next.a_mode_field = m[3:0];
        end
        OFS_TBMR: begin
          m = wmerge({28'h0, s_reg.tbmr}, s_axi_wdata, s_axi_wstrb);
          s_next.tbmr = m[3:0];
        end
        OFS_CTL: begin
          m = wmerge({16'h0, s_reg.ctl}, s_axi_wdata, s_axi_wstrb);
          s_next.ctl = m[15:0];
        end
        OFS_IMR: begin
          m = wmerge({28'h0, s_reg.imr}, s_axi_wdata, s_axi_wstrb);
          s_next.imr = m[3:0];
        end
        OFS_TAILR: begin
          if (is32(s_reg.cfg)) begin
            m = wmerge(load32, s_axi_wdata, s_axi_wstrb);
            s_next.tailr = m[15:0];
            s_next.tbilr = m[31:16];
            if (s_reg.cfg == CFG_32_TIMER) begin
              cnt_n = m;
            end
          end else begin
            m = wmerge({16'h0, s_reg.tailr}, s_axi_wdata, s_axi_wstrb);
            s_next.tailr = m[15:0];
          end
        end
        OFS_TBILR: begin
          m = wmerge({16'h0, s_reg.tbilr}, s_axi_wdata, s_axi_wstrb);
          s_next.tbilr = m[15:0];
        end
        OFS_TAMTCH: begin
          s_next.match = wmerge(s_reg.match, s_axi_wdata, s_axi_wstrb);
        end
        OFS_TAPR: begin
          m = wmerge({24'h0, s_reg.tapr}, s_axi_wdata, s_axi_wstrb);
          s_next.tapr = m[7:0];
        end
        OFS_TBPR: begin
          m = wmerge({24'h0, s_reg.tbpr}, s_axi_wdata, s_axi_wstrb);
          s_next.tbpr = m[7:0];
        end
        default: begin
          m = 32'h00000000;
        end
      endcase
    end
    s_next.ta_cnt = cnt_n[15:0];
    s_next.tb_cnt = cnt_n[31:16];

    // Read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.arready && !s_reg.rvalid) begin
      s_next.arready = 1'b1;
    end
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      case (ra)
        OFS_CFG:    s_next.rdata = {29'h0, s_reg.cfg};
        OFS_A_MODE_FIELD:   s_next.rdata = {28'h0, s_reg.a_mode_field};
        OFS_TBMR:   s_next.rdata = {28'h0, s_reg.tbmr};
        OFS_CTL:    s_next.rdata = {16'h0, s_reg.ctl};
        OFS_IMR:    s_next.rdata = {28'h0, s_reg.imr};
        OFS_RIS:    s_next.rdata = {28'h0, s_reg.ris};
        OFS_MIS:    s_next.rdata = {28'h0, s_reg.ris & s_reg.imr};
        OFS_TAILR:  s_next.rdata = is32(s_reg.cfg) ? load32 : {16'h0, s_reg.tailr};
        OFS_TBILR:  s_next.rdata = {16'h0, s_reg.tbilr};
        OFS_TAMTCH: s_next.rdata = s_reg.match;
        OFS_TAPR:   s_next.rdata = {24'h0, s_reg.tapr};
        OFS_TBPR:   s_next.rdata = {24'h0, s_reg.tbpr};
        OFS_TAR:    s_next.rdata = is32(s_reg.cfg) ? cnt : {16'h0, s_reg.ta_cnt};
        OFS_TBR:    s_next.rdata = {16'h0, s_reg.tb_cnt};
        default:    s_next.rdata = 32'h00000000;
      endcase
    end

    s_next.adc_trig = s_next.own_trig || peer_trigger;
    s_next.irq = |(s_next.ris & s_next.imr);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.ta_cnt <= RST_CNT16;
      s_reg.tb_cnt <= RST_CNT16;
      s_reg.tailr <= RST_LOAD16;
      s_reg.tbilr <= RST_LOAD16;
      s_reg.tapr <= RST_PRESC;
      s_reg.tbpr <= RST_PRESC;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign adc_trigger   = s_reg.adc_trig;
  assign irq_out       = s_reg.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_reload_after_zero: assert property (
    (s_reg.cfg == CFG_32_TIMER && s_reg.ctl[CTL_A_EN] && !stalled && cnt == 32'h0
     && !wr_fire) |=> {s_reg.tb_cnt, s_reg.ta_cnt} == $past(load32))
    else $error("counter did not reload after zero");
  a_oneshot_stops: assert property (
    (s_reg.cfg == CFG_32_TIMER && s_reg.ctl[CTL_A_EN] && !stalled && cnt == 32'h0
     && s_reg.a_mode_field[1:0] == MODE_ONESHOT && !wr_fire) |=> !s_reg.ctl[CTL_A_EN])
    else $error("one-shot enable not cleared");
  a_timeout_flag: assert property (
    s_reg.own_trig |-> s_reg.ris[IRQ_A_TO] && cnt == 32'h0)
    else $error("trigger without time-out flag at zero");
  a_trigger_width: assert property (
    s_reg.own_trig |=> !s_reg.own_trig)
    else $error("trigger wider than one cycle");
  a_trigger_adc: assert property (
    s_reg.own_trig |-> s_reg.adc_trig)
    else $error("own trigger missing on adc output");
  a_stall_holds: assert property (
    (s_reg.cfg == CFG_32_TIMER && stalled && !wr_fire) |=> $stable(cnt))
    else $error("count moved while stalled");
  a_rtc_rollover: assert property (
    (s_reg.cfg == CFG_32_RTC && s_reg.ctl[CTL_A_EN] && tick && cnt == s_reg.match
     && !wr_fire) |=> cnt == 32'h0 && s_reg.ris[IRQ_RTC])
    else $error("rtc did not roll over on match");
  a_irq_masked: assert property (
    irq_out == |(s_reg.ris & s_reg.imr))
    else $error("interrupt disagrees with masked status");
  a_concat_read: assert property (
    (rd_fire && s_axi_araddr[7:0] == OFS_TAR && is32(s_reg.cfg))
    |=> s_reg.rdata == $past(cnt))
    else $error("joined count read wrong");
endmodule
`default_nettype wire

// >>> hw/gpt_pkg.sv
`default_nettype none
package gpt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_A_MODE_FIELD   = 8'h04;
  localparam logic [7:0] OFS_TBMR   = 8'h08;
  localparam logic [7:0] OFS_CTL    = 8'h0C;
  localparam logic [7:0] OFS_IMR    = 8'h18;
  localparam logic [7:0] OFS_RIS    = 8'h1C;
  localparam logic [7:0] OFS_MIS    = 8'h20;
  localparam logic [7:0] OFS_ICR    = 8'h24;
  localparam logic [7:0] OFS_TAILR  = 8'h28;
  localparam logic [7:0] OFS_TBILR  = 8'h2C;
  localparam logic [7:0] OFS_TAMTCH = 8'h30;
  localparam logic [7:0] OFS_TAPR   = 8'h38;
  localparam logic [7:0] OFS_TBPR   = 8'h3C;
  localparam logic [7:0] OFS_TAR    = 8'h48;
  localparam logic [7:0] OFS_TBR    = 8'h4C;

  // Configuration values
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC   = 3'h1;
  localparam logic [2:0] CFG_16_SPLIT = 3'h4;

  // Mode field values
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;

  // Control bit positions
  localparam int CTL_A_EN    = 0;
  localparam int CTL_A_STALL = 1;
  localparam int CTL_RTC_EN  = 4;
  localparam int CTL_A_OTE   = 5;
  localparam int CTL_B_STALL = 9;

  // Status, mask and clear bit positions
  localparam int IRQ_A_TO  = 0;
  localparam int IRQ_RTC   = 3;

  // Reset values and RTC start count
  localparam logic [15:0] RST_CNT16  = 16'hFFFF;
  localparam logic [15:0] RST_LOAD16 = 16'hFFFF;
  localparam logic [7:0]  RST_PRESC  = 8'h00;
  localparam logic [31:0] RTC_START  = 32'h00000001;

  // Real-time clock divide
  localparam int RTC_PIN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV = RTC_PIN_HZ / RTC_TICK_HZ;
  localparam int RTC_DIV_W = $clog2(RTC_DIV);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> testbench/gp_timer_32bit_modes_test.sv
`default_nettype none
module gp_timer_32bit_modes_test
  import gpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk          = 1'b0;
  logic        resetn        = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h00000000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic        ccp_even_in   = 1'b0;
  logic        stall_in      = 1'b0;
  logic        peer_trigger  = 1'b0;
  logic        adc_trigger;
  logic        irq_out;
  logic [1:0]  last_resp;
  logic [31:0] rd_val;
  int          fail_count    = 0;
  int          n_compared    = 0;
  int          cyc           = 0;
  int          trig_q[$];

  gpt_timer DUT (
    .mclk          (mclk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ccp_even_in   (ccp_even_in),
    .stall_in      (stall_in),
    .peer_trigger  (peer_trigger),
    .adc_trigger   (adc_trigger),
    .irq_out       (irq_out)
  );

  always #5 mclk = ~mclk;

  // Log the cycle of every trigger cycle, so pulse width and spacing show
  always @(posedge mclk) begin
    cyc++;
    if (adc_trigger === 1'b1) begin
      trig_q.push_back(cyc);
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val    = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, rd_val, exp);
  endtask

  // Two count samples apart tell whether the count is moving
  task automatic moving(input logic exp);
    logic [31:0] first;
    rd(OFS_TAR);
    first = rd_val;
    repeat (5) @(posedge mclk);
    rd(OFS_TAR);
    chk("count moving", {31'h0, first !== rd_val}, {31'h0, exp});
  endtask

  task automatic pin_edges(input int n);
    repeat (n) begin
      @(posedge mclk) ccp_even_in <= 1'b1;
      @(posedge mclk) ccp_even_in <= 1'b0;
    end
  endtask

  // Watchdog: the RTC scenario alone needs about 65,600 clock cycles
  initial begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rchk("config", OFS_CFG, 32'h0);
    rchk("control", OFS_CTL, 32'h0);
    rchk("joined count", OFS_TAR, 32'hFFFFFFFF);
    rchk("joined load", OFS_TAILR, {RST_LOAD16, RST_LOAD16});
    rchk("b load", OFS_TBILR, {16'h0, RST_LOAD16});
    rchk("b count", OFS_TBR, {16'h0, RST_CNT16});
    rchk("a prescale", OFS_TAPR, {24'h0, RST_PRESC});
    rchk("b prescale", OFS_TBPR, {24'h0, RST_PRESC});
    chk("mapped rresp", {30'h0, last_resp}, {30'h0, RESP_OKAY});
    wr(8'hF0, 32'h1);
    chk("unmapped bresp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    rd(8'hFC);
    chk("unmapped rresp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd_val, 32'h0);
    wr(OFS_TBR, 32'h00001234);
    chk("mapped bresp", {30'h0, last_resp}, {30'h0, RESP_OKAY});
    rchk("b count read-only", OFS_TBR, 32'h0000FFFF);
    // Peer trigger passes through with one cycle of delay
    @(posedge mclk) peer_trigger <= 1'b1;
    @(posedge mclk) peer_trigger <= 1'b0;
    @(posedge mclk) chk("peer trigger", {31'h0, adc_trigger}, 32'h1);
    @(posedge mclk) chk("peer trigger end", {31'h0, adc_trigger}, 32'h0);
    wr(OFS_TAILR, 32'h00020010);
    rchk("b load upper", OFS_TBILR, 32'h00000002);
    rchk("joined count", OFS_TAR, 32'h00020010);
    rchk("b count upper", OFS_TBR, 32'h00000002);
    wr(OFS_CFG, {29'h0, CFG_16_SPLIT});
    rchk("split config", OFS_CFG, 32'h4);
    wr(OFS_TAILR, 32'h00070008);
    rchk("b load in split", OFS_TBILR, 32'h2);
    wr(OFS_CFG, {29'h0, CFG_32_TIMER});
    // One-shot, with the B mode set the other way
    wr(OFS_IMR, 32'h1 << IRQ_A_TO);
    wr(OFS_A_MODE_FIELD, {30'h0, MODE_ONESHOT});
    wr(OFS_TBMR, {30'h0, MODE_PERIODIC});
    wr(OFS_TAILR, 32'h00000005);
    trig_q.delete();
    wr(OFS_CTL, (32'h1 << CTL_A_EN) | (32'h1 << CTL_A_OTE));
    repeat (30) @(posedge mclk);
    chk("one-shot trigger cycles", 32'(trig_q.size()), 32'h1);
    rchk("control after one-shot", OFS_CTL, 32'h1 << CTL_A_OTE);
    rchk("count after reload", OFS_TAR, 32'h5);
    rchk("raw status", OFS_RIS, 32'h1);
    rchk("masked status", OFS_MIS, 32'h1);
    chk("irq", {31'h0, irq_out}, 32'h1);
    wr(OFS_ICR, 32'h1 << IRQ_A_TO);
    rchk("raw after clear", OFS_RIS, 32'h0);
    chk("irq after clear", {31'h0, irq_out}, 32'h0);
    // Periodic, with the B mode set to one-shot
    wr(OFS_A_MODE_FIELD, {30'h0, MODE_PERIODIC});
    wr(OFS_TBMR, {30'h0, MODE_ONESHOT});
    wr(OFS_TAILR, 32'h00000003);
    trig_q.delete();
    wr(OFS_CTL, (32'h1 << CTL_A_EN) | (32'h1 << CTL_A_OTE));
    repeat (20) @(posedge mclk);
    wr(OFS_CTL, 32'h0);
    chk("periodic pulses", 32'(trig_q.size() >= 3), 32'h1);
    chk("periodic spacing", 32'(trig_q[2] - trig_q[1]), 32'h4);
    wr(OFS_ICR, 32'h1 << IRQ_A_TO);
    // Load written while running
    wr(OFS_TAILR, 32'h00001000);
    wr(OFS_CTL, 32'h1 << CTL_A_EN);
    repeat (10) @(posedge mclk);
    wr(OFS_TAILR, 32'h00300000);
    rd(OFS_TAR);
    chk("count after new load", 32'(rd_val <= 32'h00300000 && rd_val > 32'h002FFF00),
        32'h1);
    @(posedge mclk) stall_in <= 1'b1;
    moving(1'b1);
    wr(OFS_CTL, (32'h1 << CTL_A_EN) | (32'h1 << CTL_A_STALL));
    moving(1'b0);
    @(posedge mclk) stall_in <= 1'b0;
    moving(1'b1);
    wr(OFS_CTL, 32'h0);
    @(posedge mclk) stall_in <= 1'b1;
    // Real-time clock with both stall bits set and stall asserted
    wr(OFS_CFG, {29'h0, CFG_32_RTC});
    rchk("rtc start", OFS_TAR, RTC_START);
    wr(OFS_TAMTCH, 32'h00000001);
    wr(OFS_IMR, 32'h1 << IRQ_RTC);
    wr(OFS_CTL, 32'h213);
    pin_edges(RTC_DIV - 1);
    repeat (6) @(posedge mclk);
    rchk("rtc before tick", OFS_TAR, 32'h1);
    pin_edges(1);
    repeat (6) @(posedge mclk);
    rchk("rtc rollover", OFS_TAR, 32'h0);
    rchk("rtc raw", OFS_RIS, 32'h1 << IRQ_RTC);
    rchk("rtc masked", OFS_MIS, 32'h1 << IRQ_RTC);
    chk("rtc irq", {31'h0, irq_out}, 32'h1);
    wr(OFS_ICR, 32'h1 << IRQ_RTC);
    rchk("rtc raw cleared", OFS_RIS, 32'h0);
    rchk("rtc masked cleared", OFS_MIS, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
